// ---- verilog/occ_pkg.sv ----
// Purpose: Shared constants and types for the operator console control block
// Assumes: 18-bit memory words, 32-bit AHB-Lite register bus
// Notes: Every offset and field position, and the mute reset value, is named here once
package occ_pkg;
    // Word and address widths
    localparam int OCC_WORD_W = 18;
    localparam int OCC_ADDR_W = 14;

    // Register byte offsets
    localparam logic [7:0] OCC_OFS_CTRL = 8'h00;
    localparam logic [7:0] OCC_OFS_STATUS = 8'h04;
    localparam logic [7:0] OCC_OFS_REG_A = 8'h08;
    localparam logic [7:0] OCC_OFS_REG_B = 8'h0C;
    localparam logic [7:0] OCC_OFS_REG_C = 8'h10;
    localparam logic [7:0] OCC_OFS_REG_P = 8'h14;
    localparam logic [7:0] OCC_OFS_VIEW = 8'h18;
    localparam logic [7:0] OCC_OFS_STAGE = 8'h1C;
    localparam logic [7:0] OCC_OFS_FAULT = 8'h20;

    // Control register fields
    localparam int OCC_CTRL_MUTE_BIT = 0;
    localparam int OCC_CTRL_CLEAR_BIT = 1;
    localparam logic OCC_MUTE_RST = 1'b0;

    // Status register fields
    localparam int OCC_ST_MODE_LSB = 0;
    localparam int OCC_ST_RUN_BIT = 4;
    localparam int OCC_ST_LAMP_BIT = 5;
    localparam int OCC_ST_BUZZ_BIT = 6;
    localparam int OCC_ST_BUSY_BIT = 7;

    // Pushbutton indexes
    localparam int OCC_BTN_SET_A = 0;
    localparam int OCC_BTN_SET_B = 1;
    localparam int OCC_BTN_SET_C = 2;
    localparam int OCC_BTN_SET_P = 3;
    localparam int OCC_BTN_DEPOSIT = 4;
    localparam int OCC_BTN_EXAMINE = 5;
    localparam int OCC_BTN_EXECUTE = 6;
    localparam int OCC_BTN_STEP = 7;
    localparam int OCC_BTN_RUN = 8;
    localparam int OCC_BTN_N = 9;

    // Console modes
    typedef enum logic [3:0] {
        OCC_MODE_NONE,
        OCC_MODE_SET_A,
        OCC_MODE_SET_B,
        OCC_MODE_SET_C,
        OCC_MODE_SET_P,
        OCC_MODE_DEPOSIT,
        OCC_MODE_EXAMINE,
        OCC_MODE_EXECUTE
    } occ_mode_t;

    // Memory sequencer states
    typedef enum logic [1:0] {
        OCC_ST_IDLE,
        OCC_ST_WRITE,
        OCC_ST_READ
    } occ_state_t;
endpackage : occ_pkg

// ---- verilog/occ_button_sync.sv ----
// Purpose: Synchronise pushbuttons and give one pulse per press
// Assumes: Buttons are clean levels, active high while held
// Notes: The first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module occ_button_sync #(
    parameter int N = 9
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [N-1:0] btn,
    output logic [N-1:0] press
);
    logic [N-1:0] meta_r;
    logic [N-1:0] sync_r;
    logic [N-1:0] last_r;

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser and previous level per button
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= '0;
            sync_r <= '0;
            last_r <= '0;
        end else begin
            meta_r <= btn;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // Rising edge gives a single-cycle press
    assign press = sync_r & ~last_r;
endmodule : occ_button_sync
`default_nettype wire

// ---- verilog/occ_console.sv ----
// Purpose: Operator console control: register set, deposit, examine, run, alarm lamp
// Assumes: Memory port answers with mem_ack; processor reports its reads and alarm codes
// Notes: Registers visible over AHB-Lite, zero wait states, always OKAY
// Functional notes
// - Set mode loads chosen register from switches
// - Eighteen toggle switches supply load data
// - Deposit mode: staging register follows switches
// - Deposit step writes staging word, pointer plus one
// - Examine step reads word into view, advances
// - Step while running halts the processor
// - Execute then run starts at pointer
// - Lamp and buzzer flag read-data mismatch
// - Alarm-on code lights, alarm-off code extinguishes
// - Alarm-on instruction never halts the program
// - Lamp works only in examine or deposit
// - Running fault in examine or deposit with halt switch halts, saves address
`timescale 1ns/1ps
`default_nettype none
module occ_console
    import occ_pkg::*;
#(
    parameter int WORD_W = OCC_WORD_W,
    parameter int ADDR_W = OCC_ADDR_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [OCC_BTN_N-1:0] buttons,
    input wire logic [WORD_W-1:0] switches,
    input wire logic halt_on_fault,
    input wire logic alarm_on_instruction,
    input wire logic alarm_off_instruction,
    input wire logic cpu_rd_valid,
    input wire logic [ADDR_W-1:0] cpu_rd_addr,
    input wire logic [WORD_W-1:0] cpu_rd_data,
    input wire logic mem_ack,
    input wire logic [WORD_W-1:0] mem_rdata,
    output logic mem_req,
    output logic mem_we,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [WORD_W-1:0] mem_wdata,
    output logic cpu_running,
    output logic cpu_start,
    output logic [WORD_W-1:0] reg_a,
    output logic [WORD_W-1:0] reg_b,
    output logic [WORD_W-1:0] reg_c,
    output logic [ADDR_W-1:0] reg_p,
    output logic [WORD_W-1:0] view_word,
    output logic [WORD_W-1:0] stage_word,
    output logic [ADDR_W-1:0] fault_addr,
    output logic error_lamp,
    output logic buzzer
);
    occ_mode_t mode_r, mode_nxt;
    occ_state_t state_r;
    logic [OCC_BTN_N-1:0] press;
    logic running_r, lamp_r, mute_r;
    logic dph_wr_r;
    logic [7:0] dph_addr_r;

    ////////////////////////////////////////////////////////////////////////
    // Pushbutton conditioning
    occ_button_sync #(.N(OCC_BTN_N)) u_btn (
        .hclk(hclk),
        .hresetn(hresetn),
        .btn(buttons),
        .press(press)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode of presses and conditions
    wire step_p = press[OCC_BTN_STEP];
    wire run_p = press[OCC_BTN_RUN];
    wire mode_ok = (mode_r == OCC_MODE_DEPOSIT) || (mode_r == OCC_MODE_EXAMINE);
    wire idle = (state_r == OCC_ST_IDLE);
    wire halt_by_step = running_r && step_p;
    wire dep_step = step_p && !running_r && idle && (mode_r == OCC_MODE_DEPOSIT);
    wire exam_step = step_p && !running_r && idle && (mode_r == OCC_MODE_EXAMINE);
    wire run_start = run_p && !running_r && idle &&
        (mode_ok || (mode_r == OCC_MODE_EXECUTE));
    wire wr_done = (state_r == OCC_ST_WRITE) && mem_ack;
    wire rd_done = (state_r == OCC_ST_READ) && mem_ack;
    wire [ADDR_W-1:0] p_inc = ADDR_W'(reg_p + 1'b1);
    // Read-back mismatch against the switches, console or processor read
    wire con_miss = rd_done && (mem_rdata != switches);
    wire cpu_miss = cpu_rd_valid && (cpu_rd_data != switches);
    wire miss_evt = mode_ok && (con_miss || cpu_miss);
    wire [ADDR_W-1:0] miss_addr = con_miss ? reg_p : cpu_rd_addr;
    wire fault_halt = miss_evt && running_r && halt_on_fault;
    wire lamp_set = miss_evt || (mode_ok && alarm_on_instruction);
    wire lamp_clr = alarm_off_instruction || (dph_wr_r && dph_addr_r == OCC_OFS_CTRL &&
        hwdata[OCC_CTRL_CLEAR_BIT]);

    ////////////////////////////////////////////////////////////////////////
    // Mode selection, last press wins, held otherwise
    always_comb begin
        mode_nxt = mode_r;
        if (press[OCC_BTN_SET_A]) mode_nxt = OCC_MODE_SET_A;
        if (press[OCC_BTN_SET_B]) mode_nxt = OCC_MODE_SET_B;
        if (press[OCC_BTN_SET_C]) mode_nxt = OCC_MODE_SET_C;
        if (press[OCC_BTN_SET_P]) mode_nxt = OCC_MODE_SET_P;
        if (press[OCC_BTN_DEPOSIT]) mode_nxt = OCC_MODE_DEPOSIT;
        if (press[OCC_BTN_EXAMINE]) mode_nxt = OCC_MODE_EXAMINE;
        if (press[OCC_BTN_EXECUTE]) mode_nxt = OCC_MODE_EXECUTE;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) mode_r <= OCC_MODE_NONE;
        else mode_r <= mode_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Working registers follow the switches while their set mode is held, the staging word while deposit mode is held
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reg_a <= '0;
            reg_b <= '0;
            reg_c <= '0;
            stage_word <= '0;
        end else begin
            if (mode_r == OCC_MODE_SET_A) reg_a <= switches;
            if (mode_r == OCC_MODE_SET_B) reg_b <= switches;
            if (mode_r == OCC_MODE_SET_C) reg_c <= switches;
            if (mode_r == OCC_MODE_DEPOSIT) stage_word <= switches;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointer: loaded in set mode, counts up after each memory step
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) reg_p <= '0;
        else if (mode_r == OCC_MODE_SET_P) reg_p <= switches[ADDR_W-1:0];
        else if (wr_done || rd_done) reg_p <= p_inc;
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory step sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= OCC_ST_IDLE;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= '0;
            view_word <= '0;
        end else begin
            case (state_r)
                OCC_ST_IDLE: begin
                    if (dep_step) begin
                        state_r <= OCC_ST_WRITE;
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_addr <= reg_p;
                        mem_wdata <= stage_word;
                    end else if (exam_step) begin
                        state_r <= OCC_ST_READ;
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_addr <= reg_p;
                    end
                end
                OCC_ST_WRITE, OCC_ST_READ: begin
                    if (mem_ack) begin
                        state_r <= OCC_ST_IDLE;
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        if (state_r == OCC_ST_READ) view_word <= mem_rdata;
                    end
                end
                default: state_r <= OCC_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Run control and fault location
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            running_r <= 1'b0;
            cpu_start <= 1'b0;
            fault_addr <= '0;
        end else begin
            cpu_start <= run_start;
            if (run_start) running_r <= 1'b1;
            else if (halt_by_step || fault_halt) running_r <= 1'b0;
            if (fault_halt) fault_addr <= miss_addr;
        end
    end

    assign cpu_running = running_r;

    ////////////////////////////////////////////////////////////////////////
    // Alarm lamp state, set wins over clear; outputs gated by mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lamp_r <= 1'b0;
            error_lamp <= 1'b0;
            buzzer <= 1'b0;
        end else begin
            if (lamp_set) lamp_r <= 1'b1;
            else if (lamp_clr) lamp_r <= 1'b0;
            error_lamp <= lamp_r && mode_ok;
            buzzer <= lamp_r && mode_ok && !mute_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: address phase capture and read mux
    wire ahb_go = hsel && htrans[1] && hready;
    logic [31:0] rd_word;
    always_comb begin
        case (haddr[7:0])
            OCC_OFS_CTRL: rd_word = {31'h0, mute_r};
            OCC_OFS_STATUS: rd_word = {24'h0, !idle, buzzer, error_lamp, running_r, mode_r};
            OCC_OFS_REG_A: rd_word = {{(32-WORD_W){1'b0}}, reg_a};
            OCC_OFS_REG_B: rd_word = {{(32-WORD_W){1'b0}}, reg_b};
            OCC_OFS_REG_C: rd_word = {{(32-WORD_W){1'b0}}, reg_c};
            OCC_OFS_REG_P: rd_word = {{(32-ADDR_W){1'b0}}, reg_p};
            OCC_OFS_VIEW: rd_word = {{(32-WORD_W){1'b0}}, view_word};
            OCC_OFS_STAGE: rd_word = {{(32-WORD_W){1'b0}}, stage_word};
            OCC_OFS_FAULT: rd_word = {{(32-ADDR_W){1'b0}}, fault_addr};
            default: rd_word = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_r <= 1'b0;
            dph_addr_r <= 8'h00;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            mute_r <= OCC_MUTE_RST;
        end else begin
            dph_wr_r <= ahb_go && hwrite;
            if (ahb_go) dph_addr_r <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFF;
            if (ahb_go && !hwrite) hrdata <= (haddr[31:8] == 24'h0) ? rd_word : 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (dph_wr_r && dph_addr_r == OCC_OFS_CTRL) mute_r <= hwdata[OCC_CTRL_MUTE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_dep_issue;
        mem_req && mem_we && (mem_wdata == $past(stage_word)) && (mem_addr == $past(reg_p));
    endsequence
    sequence s_exam_issue;
        mem_req && !mem_we && (mem_addr == $past(reg_p));
    endsequence
    sequence s_read_return;
        (view_word == $past(mem_rdata)) && (reg_p == $past(p_inc));
    endsequence

    property p_set_load;
        (mode_r == OCC_MODE_SET_A) ##1 (mode_r == OCC_MODE_SET_A) |-> reg_a == $past(switches);
    endproperty
    a_set_load: assert property (p_set_load) else $error("set mode did not load register");
    property p_stage;
        (mode_r == OCC_MODE_DEPOSIT) |=> stage_word == $past(switches);
    endproperty
    a_stage: assert property (p_stage) else $error("staging word not following switches");
    property p_dep;
        dep_step |=> s_dep_issue;
    endproperty
    a_dep: assert property (p_dep) else $error("deposit write not issued");
    property p_dep_inc;
        wr_done |=> (reg_p == $past(p_inc)) && !mem_req;
    endproperty
    a_dep_inc: assert property (p_dep_inc) else $error("pointer not advanced after deposit");
    property p_exam;
        exam_step |=> s_exam_issue;
    endproperty
    a_exam: assert property (p_exam) else $error("examine read not issued");
    // A pointer load in set mode takes priority over the advance
    property p_exam_ret;
        rd_done && (mode_r != OCC_MODE_SET_P) |=> s_read_return;
    endproperty
    a_exam_ret: assert property (p_exam_ret) else $error("examine did not update view and pointer");
    property p_step_halt;
        halt_by_step |=> !cpu_running;
    endproperty
    a_step_halt: assert property (p_step_halt) else $error("step did not halt");
    property p_run;
        run_start |=> cpu_running && cpu_start ##1 !cpu_start;
    endproperty
    a_run: assert property (p_run) else $error("run did not start processor");
    property p_alarm_run;
        running_r && alarm_on_instruction && !step_p && !fault_halt |=> cpu_running;
    endproperty
    a_alarm_run: assert property (p_alarm_run) else $error("alarm-on halted program");
    property p_alarm_on;
        mode_ok && alarm_on_instruction ##1 mode_ok |=> error_lamp;
    endproperty
    a_alarm_on: assert property (p_alarm_on) else $error("alarm-on did not light lamp");
    property p_gate;
        !mode_ok |=> !error_lamp && !buzzer;
    endproperty
    a_gate: assert property (p_gate) else $error("lamp active outside memory modes");
    property p_fault;
        fault_halt |=> !cpu_running && (fault_addr == $past(miss_addr)) && lamp_r;
    endproperty
    a_fault: assert property (p_fault) else $error("fault did not halt and record");
    property p_one_press;
        step_p |=> !step_p;
    endproperty
    a_one_press: assert property (p_one_press) else $error("press longer than one cycle");
endmodule : occ_console
`default_nettype wire

// ---- dv/occ_mem_model.sv ----
// Purpose: Core memory behind the console memory port
// Assumes: One request at a time, held until acknowledged
// Notes: Latency set by the bench; read data is scrambled outside the ack cycle
`timescale 1ns/1ps
`default_nettype none
module occ_mem_model
    import occ_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] lat,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [OCC_ADDR_W-1:0] mem_addr,
    input wire logic [OCC_WORD_W-1:0] mem_wdata,
    output logic mem_ack,
    output logic [OCC_WORD_W-1:0] mem_rdata
);
    logic [OCC_WORD_W-1:0] core_r [0:(1 << OCC_ADDR_W)-1];
    logic [1:0] wait_r;
    wire take = mem_req && !mem_ack && (wait_r == lat);
    ////////////////////////////////////////////////////////////////
    // Acknowledge a standing request after lat extra cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_ack <= 1'b0;
            wait_r <= 2'h0;
            mem_rdata <= 18'h0;
        end else if (take) begin
            mem_ack <= 1'b1;
            wait_r <= 2'h0;
            mem_rdata <= core_r[mem_addr];
        end else begin
            mem_ack <= 1'b0;
            wait_r <= (mem_req && !mem_ack) ? wait_r + 2'h1 : 2'h0;
            mem_rdata <= ~mem_rdata; // Stale data is inverted every cycle, so it matches the old word on alternate cycles
        end
    end
    // Store the word on the acknowledged cycle
    always_ff @(posedge hclk) begin
        if (take && mem_we) begin
            core_r[mem_addr] <= mem_wdata;
        end
    end
endmodule : occ_mem_model
`default_nettype wire

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the operator console control block
// Assumes: Zero-wait AHB-Lite slave, memory model with random latency
// Notes: Expected values come from the bench scoreboard, never from outputs
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb
    import occ_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'hB4013093;
    logic [1:0] htrans = 2'h0, lat = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [8:0] buttons = 9'h0;
    logic [17:0] switches = 18'h0, cpu_rd_data = 18'h0;
    logic halt_on_fault = 1'b0, alarm_on_instruction = 1'b0, alarm_off_instruction = 1'b0, cpu_rd_valid = 1'b0;
    logic [13:0] cpu_rd_addr = 14'h0, start_p = 14'h0;
    logic hreadyout, hresp, mem_ack, mem_req, mem_we, cpu_running, cpu_start, error_lamp, buzzer;
    logic [31:0] hrdata;
    logic [17:0] mem_rdata, mem_wdata, reg_a, reg_b, reg_c, view_word, stage_word;
    logic [13:0] mem_addr, reg_p, fault_addr;
    int error_cnt = 0, n_tests = 0, start_cnt = 0, exp_p;
    logic [17:0] core_m [int];
    occ_console occ_console_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .buttons, .switches, .halt_on_fault,
        .alarm_on_instruction, .alarm_off_instruction, .cpu_rd_valid, .cpu_rd_addr, .cpu_rd_data,
        .mem_ack, .mem_rdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .cpu_running, .cpu_start,
        .reg_a, .reg_b, .reg_c, .reg_p, .view_word, .stage_word, .fault_addr, .error_lamp, .buzzer);
    occ_mem_model occ_mem_model_i (.hclk, .hresetn, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .mem_ack, .mem_rdata);
    ////////////////////////////////////////////////////////////////
    // Clock and run-start recorder
    always #25 hclk = ~hclk;
    always @(posedge hclk) begin
        if (cpu_start === 1'b1) begin
            start_cnt <= start_cnt + 1;
            start_p <= reg_p;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    task automatic wait_rdy;
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && k < 20) begin
            @(posedge hclk);
            k++;
        end
        if (k >= 20) begin
            error_cnt++;
            test_done();
        end
    endtask : wait_rdy
    task automatic wait_p(input int e);
        int k;
        k = 0;
        while (reg_p !== 14'(e) && k < 40) begin
            @(posedge hclk);
            k++;
        end
        if (k >= 40) begin
            error_cnt++;
            test_done();
        end
    endtask : wait_p
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : ahb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        ahb(1'b0, a, 32'h0, d);
        `CHK("hrdata", e, d)
    endtask : rd_chk
    task automatic press(input int idx, input int hold);
        buttons[idx] <= 1'b1;
        repeat (hold) @(posedge hclk);
        buttons[idx] <= 1'b0;
        repeat (5) @(posedge hclk);
    endtask : press
    task automatic alarm(input logic on);
        if (on) alarm_on_instruction <= 1'b1;
        else alarm_off_instruction <= 1'b1;
        @(posedge hclk);
        alarm_on_instruction <= 1'b0;
        alarm_off_instruction <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask : alarm
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] v, d;
        logic [13:0] base;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        `CHK("hreadyout", 1'b1, hreadyout)
        `CHK("hresp", 1'b0, hresp)
        rd_chk(OCC_OFS_STATUS, 32'h0);
        rd_chk(8'h24, 32'h0);
        ahb(1'b1, OCC_OFS_CTRL, 32'h1, d);
        rd_chk(OCC_OFS_CTRL, 32'h1);
        ahb(1'b1, OCC_OFS_CTRL, 32'h0, d);
        rd_chk(OCC_OFS_CTRL, 32'h0);
        $display("test reset_and_map done");
        // Set modes load A, B and C from all 18 switches and P from the low 14
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            switches <= v[17:0];
            press(i, 2);
            rd_chk(OCC_OFS_REG_A + 8'(4 * i), (i == 3) ? {18'h0, v[13:0]} : {14'h0, v[17:0]});
            rd_chk(OCC_OFS_STATUS, 32'(i + 1));
        end
        base = 14'(rnd());
        switches <= {4'h0, base};
        repeat (2) @(posedge hclk);
        `CHK("reg_p", base, reg_p)
        exp_p = base;
        $display("test set_modes done");
        // Deposit four words, last step held long
        press(OCC_BTN_DEPOSIT, 2);
        for (int k = 0; k < 4; k++) begin
            v = rnd();
            lat <= v[21:20];
            switches <= v[17:0];
            repeat (2) @(posedge hclk);
            `CHK("stage_word", v[17:0], stage_word)
            core_m[exp_p] = v[17:0];
            exp_p = (exp_p + 1) % (1 << OCC_ADDR_W);
            press(OCC_BTN_STEP, (k == 3) ? 8 : 1);
            wait_p(exp_p);
            repeat (6) @(posedge hclk);
            `CHK("reg_p", 14'(exp_p), reg_p)
        end
        $display("test deposit done");
        // Examine them back; the last read mismatches the switches
        switches <= {4'h0, base};
        press(OCC_BTN_SET_P, 2);
        press(OCC_BTN_EXAMINE, 2);
        exp_p = base;
        for (int k = 0; k < 4; k++) begin
            lat <= 2'(3 - k);
            switches <= (k == 3) ? ~core_m[exp_p] : core_m[exp_p];
            d = {14'h0, core_m[exp_p]};
            exp_p = (exp_p + 1) % (1 << OCC_ADDR_W);
            press(OCC_BTN_STEP, 1);
            wait_p(exp_p);
            repeat (3) @(posedge hclk);
            `CHK("view_word", d[17:0], view_word)
            `CHK("error_lamp", k == 3, error_lamp)
        end
        `CHK("buzzer", 1'b1, buzzer)
        ahb(1'b1, OCC_OFS_CTRL, 32'h1, d);
        repeat (2) @(posedge hclk);
        `CHK("buzzer", 1'b0, buzzer)
        ahb(1'b1, OCC_OFS_CTRL, 32'h2, d);
        repeat (2) @(posedge hclk);
        `CHK("error_lamp", 1'b0, error_lamp)
        $display("test examine done");
        // Run in examine mode, alarm codes, then a halting fault
        halt_on_fault <= 1'b1;
        press(OCC_BTN_RUN, 2);
        `CHK("start_p", 14'(exp_p), start_p)
        rd_chk(OCC_OFS_STATUS, 32'h16);
        alarm(1'b1);
        `CHK("lamp_buzz", 2'h3, {error_lamp, buzzer})
        `CHK("cpu_running", 1'b1, cpu_running)
        alarm(1'b0);
        `CHK("lamp_buzz", 2'h0, {error_lamp, buzzer})
        v = rnd();
        cpu_rd_addr <= v[13:0];
        cpu_rd_data <= ~switches;
        cpu_rd_valid <= 1'b1;
        @(posedge hclk);
        cpu_rd_valid <= 1'b0;
        cpu_rd_data <= switches;
        cpu_rd_addr <= ~v[13:0];
        repeat (3) @(posedge hclk);
        `CHK("cpu_running", 1'b0, cpu_running)
        `CHK("fault_addr", v[13:0], fault_addr)
        rd_chk(OCC_OFS_FAULT, {18'h0, v[13:0]});
        `CHK("error_lamp", 1'b1, error_lamp)
        ahb(1'b1, OCC_OFS_CTRL, 32'h2, d);
        press(OCC_BTN_RUN, 2);
        press(OCC_BTN_STEP, 3);
        `CHK("cpu_running", 1'b0, cpu_running)
        `CHK("reg_p", 14'(exp_p), reg_p)
        $display("test run_fault done");
        // Execute mode starts at the pointer; lamp is dead here
        v = rnd();
        switches <= v[17:0];
        press(OCC_BTN_SET_P, 2);
        press(OCC_BTN_EXECUTE, 2);
        press(OCC_BTN_RUN, 2);
        `CHK("start_cnt", 3, start_cnt)
        `CHK("start_p", v[13:0], start_p)
        alarm(1'b1);
        `CHK("lamp_buzz", 2'h0, {error_lamp, buzzer})
        `CHK("cpu_running", 1'b1, cpu_running)
        $display("test execute done");
        test_done();
    end
endmodule : tb
`default_nettype wire
